/* File: hdl/gjw_pkg.sv */
package gjw_pkg;

   // Register byte addresses.
   localparam logic [11:0] ADDR_PIN_DATA = 12'h0300;
   localparam logic [11:0] ADDR_PIN_DIR = 12'h0304;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h0308;
   localparam logic [11:0] ADDR_CHANGE = 12'h030C;
   localparam logic [11:0] ADDR_CTRL = 12'h0310;
   localparam logic [11:0] ADDR_STATUS = 12'h0314;

   // Control register field positions.
   localparam int CTRL_DEB_SEL_BIT = 0;
   localparam int CTRL_WAKE_HW_EN_BIT = 1;
   localparam int CTRL_SW_WAKE_BIT = 2;
   localparam int CTRL_WAKE_SEL_LSB = 4;

   // Status register field positions.
   localparam int STAT_WAKE_ARMED_BIT = 0;
   localparam int STAT_SUSPENDED_BIT = 1;

   // Reset values.
   localparam logic [7:0] RST_PIN_DATA = 8'h00;
   localparam logic [7:0] RST_PIN_DIR = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'hFF;
   localparam logic [7:0] RST_CTRL = 8'h00;

   // Debounce intervals.
   localparam int CLK_HZ = 20_000_000;
   localparam int DEB_LONG_MS = 16;
   localparam int DEB_SHORT_MS = 8;
   localparam int DEB_LONG_CYC = CLK_HZ / 1000 * DEB_LONG_MS;
   localparam int DEB_SHORT_CYC = CLK_HZ / 1000 * DEB_SHORT_MS;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

/* File: hdl/gjw_debounce.sv */
`timescale 1ns/1ps

// Accepts a new input level only after it has stood unchanged for the interval.
module gjw_debounce #(
   parameter int CNT_W = 19
) (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic raw, // Synchronised pin level.
   input wire logic [CNT_W-1:0] limit, // Stable cycles required.
   output logic stable_q // Debounced level.
);

   logic [CNT_W-1:0] cnt_q;

   // Counts stable cycles while the raw level differs from the accepted one.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= '0;
         stable_q <= 1'b0;
      end
      else if (raw == stable_q)
      begin
         cnt_q <= '0;
      end
      else if (cnt_q >= limit - CNT_W'(1))
      begin
         cnt_q <= '0;
         stable_q <= raw;
      end
      else
      begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

endmodule

/* File: hdl/gjw_gpio.sv */
// Behaviour
// - Each pin is input or output by its own direction bit.
// - Output pins drive the matching pin data register bit.
// - A state change on an input pin raises the processor interrupt.
// - Per-pin mask bit blocks that pin's change from the interrupt.
// - Any one selected pin can serve as the hardware wakeup source.
// - Rising edge on the wakeup source starts remote wakeup of host.
// - Wakeup is signalled only when the host has enabled the feature.
// - Pin changes pass a debounce filter of 16 ms or 8 ms.
`timescale 1ns/1ps

module gjw_gpio #(
   parameter int N_PINS = 8,
   parameter int DEB_LONG = gjw_pkg::DEB_LONG_CYC,
   parameter int DEB_SHORT = gjw_pkg::DEB_SHORT_CYC
) (
   input wire logic aclk, // System clock, 20 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [11:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic [N_PINS-1:0] pin_i, // Pin levels from the pads.
   output logic [N_PINS-1:0] pin_o, // Pin output levels.
   output logic [N_PINS-1:0] pin_oe_n, // Pin output enables, low drives.
   input wire logic wake_enabled, // Host enabled remote wakeup, from USB core.
   input wire logic suspended, // USB bus is suspended.
   output logic jack_irq_q, // Jack activity interrupt, level.
   output logic wake_req_q // Remote wakeup request, one-cycle pulse.
);

   localparam int CNT_W = $clog2(DEB_LONG + 1);
   localparam int SEL_W = $clog2(N_PINS);

   logic [N_PINS-1:0] data_q, dir_q, mask_q, chg_q, last_q, sync1_q, sync2_q, deb;
   logic deb_sel_q, hw_en_q, sw_wake_q, sw_wake_prev_q, hw_prev_q;
   logic [SEL_W-1:0] wake_sel_q;
   logic [11:0] aw_q;
   logic aw_have_q, w_have_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic wr_go, wr_hit;
   logic [CNT_W-1:0] deb_limit;
   logic [N_PINS-1:0] chg_now;

   // Two-flop synchroniser for pad inputs.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
      end
   end

   assign deb_limit = deb_sel_q ? CNT_W'(DEB_SHORT) : CNT_W'(DEB_LONG);

   // One debounce filter per pin.
   for (genvar i = 0; i < N_PINS; i++)
   begin : g_deb
      gjw_debounce #(.CNT_W(CNT_W)) u_deb (
         .aclk(aclk),
         .aresetn(aresetn),
         .raw(sync2_q[i]),
         .limit(deb_limit),
         .stable_q(deb[i])
      );
   end

   assign chg_now = (deb ^ last_q) & ~dir_q;

   // Stores the last debounced level for change detection.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         last_q <= '0;
      else
         last_q <= deb;
   end

   // Write channel capture; address and data may arrive in either order.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= gjw_pkg::RESP_OKAY;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
      else
      begin
         // Each ready falls when its channel is taken and rises again once the response is accepted.
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? gjw_pkg::RESP_OKAY : gjw_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_hit = aw_q == gjw_pkg::ADDR_PIN_DATA || aw_q == gjw_pkg::ADDR_PIN_DIR ||
                   aw_q == gjw_pkg::ADDR_IRQ_MASK || aw_q == gjw_pkg::ADDR_CHANGE ||
                   aw_q == gjw_pkg::ADDR_CTRL || aw_q == gjw_pkg::ADDR_STATUS;

   // Software registers, written through byte lane 0.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_q <= gjw_pkg::RST_PIN_DATA[N_PINS-1:0];
         dir_q <= gjw_pkg::RST_PIN_DIR[N_PINS-1:0];
         mask_q <= gjw_pkg::RST_IRQ_MASK[N_PINS-1:0];
         deb_sel_q <= gjw_pkg::RST_CTRL[gjw_pkg::CTRL_DEB_SEL_BIT];
         hw_en_q <= gjw_pkg::RST_CTRL[gjw_pkg::CTRL_WAKE_HW_EN_BIT];
         sw_wake_q <= gjw_pkg::RST_CTRL[gjw_pkg::CTRL_SW_WAKE_BIT];
         wake_sel_q <= gjw_pkg::RST_CTRL[gjw_pkg::CTRL_WAKE_SEL_LSB +: SEL_W];
      end
      else if (wr_go && ws_q[0])
      begin
         case (aw_q)
            gjw_pkg::ADDR_PIN_DIR: dir_q <= wd_q[N_PINS-1:0];
            gjw_pkg::ADDR_PIN_DATA: data_q <= wd_q[N_PINS-1:0];
            gjw_pkg::ADDR_IRQ_MASK: mask_q <= wd_q[N_PINS-1:0];
            gjw_pkg::ADDR_CTRL:
            begin
               deb_sel_q <= wd_q[gjw_pkg::CTRL_DEB_SEL_BIT];
               hw_en_q <= wd_q[gjw_pkg::CTRL_WAKE_HW_EN_BIT];
               sw_wake_q <= wd_q[gjw_pkg::CTRL_SW_WAKE_BIT];
               wake_sel_q <= wd_q[gjw_pkg::CTRL_WAKE_SEL_LSB +: SEL_W];
            end
            default: ;
         endcase
      end
   end

   // Sticky change flags; a new change wins over a write-one clear.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         chg_q <= '0;
      else if (wr_go && ws_q[0] && aw_q == gjw_pkg::ADDR_CHANGE)
         chg_q <= (chg_q & ~wd_q[N_PINS-1:0]) | chg_now;
      else
         chg_q <= chg_q | chg_now;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         jack_irq_q <= 1'b0;
      else
         jack_irq_q <= |(((chg_q & ~mask_q) | (chg_now & ~mask_q)) &
                         ~((wr_go && ws_q[0] && aw_q == gjw_pkg::ADDR_CHANGE) ? wd_q[N_PINS-1:0] & ~chg_now : '0));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hw_prev_q <= 1'b0;
         sw_wake_prev_q <= 1'b0;
         wake_req_q <= 1'b0;
      end
      else
      begin
         hw_prev_q <= deb[wake_sel_q];
         sw_wake_prev_q <= sw_wake_q;
         wake_req_q <= wake_enabled && suspended &&
                       ((hw_en_q && deb[wake_sel_q] && !hw_prev_q) || (sw_wake_q && !sw_wake_prev_q));
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_o <= '0;
         pin_oe_n <= '1;
      end
      else
      begin
         pin_o <= data_q;
         pin_oe_n <= ~dir_q;
      end
   end

   // Read channel; one cycle after address acceptance.
   // pin data readback
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= gjw_pkg::RESP_OKAY;
         s_axi_arready <= 1'b1;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0; // No new read while the answer stands.
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= gjw_pkg::RESP_OKAY;
         s_axi_rdata <= '0;
         case (s_axi_araddr)
            gjw_pkg::ADDR_PIN_DATA: s_axi_rdata[N_PINS-1:0] <= (dir_q & data_q) | (~dir_q & deb);
            gjw_pkg::ADDR_PIN_DIR: s_axi_rdata[N_PINS-1:0] <= dir_q;
            gjw_pkg::ADDR_IRQ_MASK: s_axi_rdata[N_PINS-1:0] <= mask_q;
            gjw_pkg::ADDR_CHANGE: s_axi_rdata[N_PINS-1:0] <= chg_q;
            gjw_pkg::ADDR_CTRL:
            begin
               s_axi_rdata[gjw_pkg::CTRL_DEB_SEL_BIT] <= deb_sel_q;
               s_axi_rdata[gjw_pkg::CTRL_WAKE_HW_EN_BIT] <= hw_en_q;
               s_axi_rdata[gjw_pkg::CTRL_SW_WAKE_BIT] <= sw_wake_q;
               s_axi_rdata[gjw_pkg::CTRL_WAKE_SEL_LSB +: SEL_W] <= wake_sel_q;
            end
            gjw_pkg::ADDR_STATUS:
            begin
               s_axi_rdata[gjw_pkg::STAT_WAKE_ARMED_BIT] <= wake_enabled;
               s_axi_rdata[gjw_pkg::STAT_SUSPENDED_BIT] <= suspended;
            end
            default: s_axi_rresp <= gjw_pkg::RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

/* File: test/gjw_jacks.sv */
`timescale 1ns/1ps

// Jack switches behind the pads.
module gjw_jacks (
   input wire logic [7:0] lvl, // Switch levels.
   input wire logic [7:0] pin_o, // Block pin levels.
   input wire logic [7:0] pin_oe_n, // Block enables, low drives.
   output logic [7:0] pin_i // Resolved pad levels.
);
   // A driven pad shows the block's level, any other pad the switch level.
   assign pin_i = (pin_o & ~pin_oe_n) | (lvl & pin_oe_n);
endmodule

/* File: test/gjw_gpio_checker.sv */
`timescale 1ns/1ps

// Watches the bus handshakes, the pin outputs and the wakeup pulse.
module gjw_gpio_checker (
   input wire logic aclk, // Clock.
   input wire logic aresetn, // Reset, active low.
   input wire logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address ready.
   input wire logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data ready.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic [31:0] s_axi_rdata, // Read data.
   input wire logic [7:0] pin_o, // Pin levels.
   input wire logic wake_enabled, // Host enable.
   input wire logic suspended, // Bus suspended.
   input wire logic wake_req_q // Wakeup pulse.
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Accepted write and read requests.
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_write_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
      else $error("write not answered");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answering");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_out_follow: assert property ($changed(pin_o) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("pin level moved without a write");
   a_wake_pulse: assert property (wake_req_q |=> !wake_req_q)
      else $error("wakeup pulse too long");
   a_wake_gate: assert property (wake_req_q |-> $past(wake_enabled) && $past(suspended))
      else $error("wakeup while not enabled");
endmodule

/* File: test/gjw_gpio_test.sv */
`timescale 1ns/1ps

module gjw_gpio_test;
   logic aclk = 0;
   logic aresetn = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, jack_irq_q, wake_req_q;
   logic wake_enabled = 0, suspended = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] lvl = 0, pin_i, pin_o, pin_oe_n;
   logic [33:0] q[$];
   int bad_count = 0, samples_checked = 0, wakes = 0, seed = 6, n;

   always #25 aclk = ~aclk;

   gjw_gpio #(.DEB_LONG(16), .DEB_SHORT(8)) i_gjw_gpio (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .pin_i(pin_i),
      .pin_o(pin_o),
      .pin_oe_n(pin_oe_n),
      .wake_enabled(wake_enabled),
      .suspended(suspended),
      .jack_irq_q(jack_irq_q),
      .wake_req_q(wake_req_q)
   );
   gjw_jacks i_gjw_jacks (.lvl, .pin_o, .pin_oe_n, .pin_i);

   task chk(input logic [33:0] s, input logic [33:0] e);
      samples_checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("mismatch t=%0t seen %h exp %h", $time, s, e);
      end
   endtask

   task conclude;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One edge of a bounded wait; a spent bound ends the run.
   task tick(input int i);
      @(posedge aclk);
      if (i > 200)
      begin
         bad_count++;
         conclude;
      end
   endtask

   // Write with both channels offered; bready rises late to stall the answer.
   task wr(input logic [11:0] a, input logic [31:0] d);
      int i;
      q.push_back({gjw_pkg::RESP_OKAY, 32'h0000_0000});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      for (i = 0; 1; i++)
      begin
         tick(i);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) s_axi_bready <= 1;
      end
      s_axi_bready <= 0;
   endtask

   // Read whose answer is noted for the monitor; rready also rises late.
   task rd(input logic [11:0] a, input logic [33:0] e);
      int i;
      q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      for (i = 0; 1; i++)
      begin
         tick(i);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (!s_axi_arvalid) s_axi_rready <= 1;
      end
      s_axi_rready <= 0;
   endtask

   // Counts cycles until the interrupt shows.
   task wirq(output int k);
      for (k = 0; k < 40 && jack_irq_q !== 1'b1; k++) @(posedge aclk);
   endtask

   // Compares every bus answer with the oldest note and counts wakeups.
   always @(posedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0000_0000}, q.pop_front());
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
      if (wake_req_q === 1'b1) wakes++;
   end

   // Watchdog for the whole run.
   initial
   begin
      repeat (60000) @(posedge aclk);
      bad_count++;
      conclude;
   end

   // Main sequence.
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rd(gjw_pkg::ADDR_PIN_DIR, 34'h0);
      rd(gjw_pkg::ADDR_IRQ_MASK, 34'hFF);
      rd(gjw_pkg::ADDR_CTRL, 34'h0);
      rd(12'h03F0, {gjw_pkg::RESP_SLVERR, 32'h0000_0000});
      // A write without lane 0 leaves the register alone.
      s_axi_wstrb <= 4'h0;
      wr(gjw_pkg::ADDR_PIN_DIR, 32'h0000_00FF);
      s_axi_wstrb <= 4'hF;
      rd(gjw_pkg::ADDR_PIN_DIR, 34'h0);
      r = $random(seed);
      wr(gjw_pkg::ADDR_PIN_DIR, {24'h00_0000, r[7:0]});
      wr(gjw_pkg::ADDR_PIN_DATA, {24'h00_0000, r[15:8]});
      repeat (2) @(posedge aclk);
      chk(34'(pin_oe_n ^ 8'hFF), 34'(r[7:0]));
      chk(34'(pin_o), 34'(r[15:8]));
      rd(gjw_pkg::ADDR_PIN_DATA, 34'(r[15:8] & r[7:0]));
      wr(gjw_pkg::ADDR_PIN_DATA, 32'h0000_0000);
      wr(gjw_pkg::ADDR_PIN_DIR, 32'h0000_0000);
      repeat (40) @(posedge aclk);
      wr(gjw_pkg::ADDR_CHANGE, 32'h0000_00FF);
      wr(gjw_pkg::ADDR_IRQ_MASK, 32'h0000_00FE);
      wr(gjw_pkg::ADDR_CTRL, 32'h0000_0001);
      lvl <= 8'h01;
      wirq(n);
      chk(34'(n > 8 && n <= 16), 34'h1);
      rd(gjw_pkg::ADDR_CHANGE, 34'h1);
      wr(gjw_pkg::ADDR_CHANGE, 32'h0000_0001);
      repeat (2) @(posedge aclk);
      chk(34'(jack_irq_q), 34'h0);
      wr(gjw_pkg::ADDR_CTRL, 32'h0000_0000);
      lvl <= 8'h00;
      wirq(n);
      chk(34'(n > 16 && n <= 24), 34'h1);
      wr(gjw_pkg::ADDR_CHANGE, 32'h0000_0001);
      lvl <= 8'h02;
      repeat (40) @(posedge aclk);
      chk(34'(jack_irq_q), 34'h0);
      // A pulse shorter than the interval on a masked pin is filtered out.
      lvl <= 8'h06;
      repeat (5) @(posedge aclk);
      lvl <= 8'h02;
      repeat (30) @(posedge aclk);
      chk(34'(jack_irq_q), 34'h0);
      rd(gjw_pkg::ADDR_CHANGE, 34'h2);
      rd(gjw_pkg::ADDR_PIN_DATA, 34'h2);
      // software wakeup gated by the host enable.
      suspended <= 1;
      wr(gjw_pkg::ADDR_CTRL, 32'h0000_0004);
      wr(gjw_pkg::ADDR_CTRL, 32'h0000_0000);
      wake_enabled <= 1;
      rd(gjw_pkg::ADDR_STATUS, 34'h3);
      wr(gjw_pkg::ADDR_CTRL, 32'h0000_0004);
      repeat (4) @(posedge aclk);
      chk(34'(wakes), 34'h1);
      // hardware source on pin three only.
      wr(gjw_pkg::ADDR_CTRL, 32'h0000_0032);
      lvl <= 8'h0A;
      repeat (40) @(posedge aclk);
      chk(34'(wakes), 34'h2);
      lvl <= 8'h22;
      repeat (40) @(posedge aclk);
      chk(34'(wakes), 34'h2);
      conclude;
   end
endmodule

bind gjw_gpio gjw_gpio_checker i_gjw_gpio_checker (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .pin_o(pin_o),
   .wake_enabled(wake_enabled),
   .suspended(suspended),
   .wake_req_q(wake_req_q)
);
